//--- bench/sbcrw_bench.sv
`timescale 1ns/100ps
module sbcrw_bench;
    import sbcrw_pkg::*;
    logic mclk = 0, arst_n = 0, vdd_low_pin = 0, reg_overtemp_pin = 0, bus_fault_pin = 0;
    logic bus_overcurrent_pin = 0, wdcfg_grounded_pin = 0, wdcfg_open_pin = 0, wake_input = 0;
    logic bus_rx = 1, cs_n = 1, mode_wr = 0, wake_input_enable = 0, amux_wake_sel = 0, ext_low = 0;
    logic irq_ack_rd = 0, bus_status_rd = 0, rst_pin_i, rst_pin_o, rst_pin_oe, irq_n;
    logic regulator_enable, regulator_overtemp_flag, bus_driver_enable, bus_overcurrent_flag;
    logic supply_uv_pin, supply_ov_pin, reg_prewarn_pin, hs_overtemp_pin;
    logic [1:0] mode_select_bits = '0, high_side_switch = '0, hs_sense_drive;
    logic [3:0] ev = '0; // Supply and temperature events, in pending-source order
    sbcrw_timing_control_reg_t timing_control_reg = '0;
    sbcrw_mode_t op_mode;
    sbcrw_watchdog_status_reg_t watchdog_status_reg;
    sbcrw_wakeup_status_reg_t wakeup_status_reg;
    sbcrw_irq_t irq_src;
    int miscompares = 0, checks = 0, n;
    assign {supply_uv_pin, supply_ov_pin, reg_prewarn_pin, hs_overtemp_pin} = ev;
    // Short counts keep the run small; expectations below use these same figures
    sbcrw_top #(.RST_STRETCH_CYC(20), .NREQ_CYC(200), .WD_FALLBACK_CYC(64), .WD_BASE_CYC(32),
        .CYC_UNIT_CYC(40), .BUS_MIN_CYC(5), .RST_FILT_CYC(3)) sbcrw_top_i (.*);
    sbcrw_host sbcrw_host_i (.*);
    initial forever #50 mclk = ~mclk;
    initial begin
        #1ms miscompares++;
        complete_run();
    end
    task automatic cyc(int k); repeat (k) @(posedge mclk); #10; endtask
    task automatic chk(logic [7:0] seen, logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_mode(sbcrw_mode_t m); for (n = 0; n < 2000 && op_mode !== m; n++) cyc(1); endtask
    // Mode writes are spaced by an idle edge so the strobe never changes twice at once
    task automatic wr(logic [1:0] b); cyc(1); mode_wr = 1; mode_select_bits = b; cyc(1); mode_wr = 0; endtask
    task automatic rd(); bus_status_rd = 1; cyc(1); bus_status_rd = 0; cyc(1); endtask
    task automatic complete_run();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge mclk);
        #10 arst_n = 1;
        wait_mode(SBCRW_NREQ);
        chk(n >= 20, 1);
        chk({rst_pin_oe, regulator_enable, irq_n, watchdog_status_reg}, 8'h0C);
        wait_mode(SBCRW_RESET);
        chk(n > 196 && n < 202, 1);
        wait_mode(SBCRW_NREQ);
        chk(n >= 20, 1);
        for (int k = 0; k < 4; k++) begin
            ev = 4'h1 << k;
            cyc(6);
            chk({irq_n, irq_src}, {1'b0, ev, 1'b0});
            ev = '0;
            irq_ack_rd = 1;
            cyc(1);
            irq_ack_rd = 0;
            cyc(1);
            chk(irq_n, 1);
        end
        wr(2'h0);
        chk(op_mode, SBCRW_NORMAL);
        cyc(20);
        wr(2'h0);
        chk(op_mode, SBCRW_NORMAL);
        wr(2'h0);
        chk(op_mode, SBCRW_RESET);
        wait_mode(SBCRW_NREQ);
        wr(2'h0);
        wr(2'h2);
        chk(op_mode, SBCRW_STOP);
        cs_n = 0;
        cyc(2);
        cs_n = 1;
        wait_mode(SBCRW_NREQ);
        chk({n < 10, irq_n, wakeup_status_reg}, 8'h30);
        wake_input_enable = 1;
        wr(2'h0);
        wr(2'h2);
        wake_input = 1;
        wait_mode(SBCRW_NREQ);
        chk({irq_n, irq_src.wakeup, wakeup_status_reg}, 8'h1C);
        irq_ack_rd = 1;
        cyc(1);
        irq_ack_rd = 0;
        timing_control_reg.cyclic_or_watchdog_select = 1;
        wr(2'h0); // Switch enables stay off for forced wake
        wr(2'h2);
        wait_mode(SBCRW_NREQ);
        chk(n == 40, 1);
        chk({hs_sense_drive, irq_src.wakeup, wakeup_status_reg}, 8'h19);
        ext_low = 1;
        cyc(40);
        chk(op_mode, SBCRW_RESET);
        ext_low = 0;
        wait_mode(SBCRW_NREQ);
        chk(n < 12, 1);
        {vdd_low_pin, reg_overtemp_pin, wdcfg_open_pin} = 3'h7;
        cyc(9);
        chk({rst_pin_oe, regulator_enable, regulator_overtemp_flag}, 8'h05);
        {vdd_low_pin, reg_overtemp_pin} = 2'h0;
        wait_mode(SBCRW_NREQ);
        chk(watchdog_status_reg, 8'h01);
        bus_overcurrent_pin = 1;
        cyc(6);
        chk({bus_driver_enable, bus_overcurrent_flag}, 8'h03);
        {bus_overcurrent_pin, bus_fault_pin} = 2'h1;
        cyc(6);
        rd();
        chk(bus_driver_enable, 0);
        bus_fault_pin = 0;
        cyc(6);
        rd();
        chk(bus_driver_enable, 1);
        complete_run();
    end
endmodule // sbcrw_bench

//--- bench/sbcrw_checker.sv
`timescale 1ns/100ps
// Watches reset, wake, interrupt and bus-driver timing at the top ports
module sbcrw_checker #(parameter int unsigned NREQ_CYC = 200) (
    input wire logic mclk, arst_n, vdd_low_pin, reg_overtemp_pin, bus_fault_pin, // Causes
    input wire logic cs_n, bus_status_rd, rst_pin_oe, irq_n, regulator_enable,   // Pins
    input wire logic bus_driver_enable,                                          // Transmitter
    input wire sbcrw_pkg::sbcrw_mode_t op_mode,                                  // Mode
    input wire sbcrw_pkg::sbcrw_irq_t  irq_src                                   // Pending
);
    import sbcrw_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    int unsigned nreq_len; // Length of the current wait for the host
    // Restarts whenever the mode is left, so a missed timeout shows as overflow
    always_ff @(posedge mclk or negedge arst_n)
        if (!arst_n) nreq_len <= 0;
        else nreq_len <= (op_mode == SBCRW_NREQ) ? nreq_len + 1 : 0;
    sequence s_cs_wake; op_mode == SBCRW_STOP && $rose(cs_n); endsequence
    property p_irq; irq_n == (irq_src == '0); endproperty
    a_irq: assert property (p_irq) else $error("irq line disagrees with sources");
    property p_ovt; reg_overtemp_pin [*8] |-> !regulator_enable; endproperty
    a_ovt: assert property (p_ovt) else $error("regulator kept on when hot");
    property p_vdd; vdd_low_pin [*8] |-> rst_pin_oe && op_mode == SBCRW_RESET; endproperty
    a_vdd: assert property (p_vdd) else $error("no reset on low regulator");
    property p_rel; $fell(rst_pin_oe) |-> ##[0:1] op_mode inside {SBCRW_NREQ, SBCRW_NORMAL}; endproperty
    a_rel: assert property (p_rel) else $error("reset released into wrong mode");
    property p_csq; s_cs_wake |-> !irq_src.wakeup [*8]; endproperty
    a_csq: assert property (p_csq) else $error("chip select wake raised irq");
    property p_nreq; nreq_len <= NREQ_CYC; endproperty
    a_nreq: assert property (p_nreq) else $error("request mode outlived timeout");
    property p_flt; bus_fault_pin [*8] |-> !bus_driver_enable; endproperty
    a_flt: assert property (p_flt) else $error("driver on during bus fault");
    property p_drv; $rose(bus_driver_enable) |-> $past(bus_status_rd); endproperty
    a_drv: assert property (p_drv) else $error("driver resumed without read");
endmodule // sbcrw_checker
bind sbcrw_top sbcrw_checker #(.NREQ_CYC(NREQ_CYC)) sbcrw_checker_i (.*);

//--- bench/sbcrw_host.sv
`timescale 1ns/100ps
// Host side of the open-drain reset wire; the pull-up wins unless someone drives low
module sbcrw_host (
    input  wire logic ext_low,    // Host pulls the pin low
    input  wire logic rst_pin_o,  // Device drive level
    input  wire logic rst_pin_oe, // Device drive enable
    output logic      rst_pin_i   // Resolved pin level
);
    assign rst_pin_i = !ext_low && !(rst_pin_oe && !rst_pin_o);
endmodule // sbcrw_host

//--- design/sbcrw_consts.svh
`ifndef SBCRW_CONSTS_SVH
`define SBCRW_CONSTS_SVH
// Overview of operation
// - Reset held low, then stretched before release
// - Regulator below threshold issues a reset
// - Regulator overtemperature disables regulator, sets flag
// - Early or missing watchdog clear resets host
// - First half of watchdog period is closed
// - Grounded config pin in Reset disables watchdog
// - Open config pin selects fallback timebase, flagged
// - Prescaler from timing register multiplies timebase
// - Normal Request timeout enters Reset, then returns
// - Filtered external reset holds Reset, no stretch
// - Stop wake interrupts; Sleep wake resets host
// - Chip select rise wakes Stop silently
// - Direct wake needs enable; level readable
// - Multiplexed wake input ignored in low power
// - Cyclic sense pulses switch, wakes on change
// - Cyclic sense and forced wake mutually exclusive
// - Bus wake needs long dominant then release
// - Reset pin in Stop wakes, no interrupt
// - Bus driver resumes after fault gone and read
// - Interrupts for supply and temperature events
// - Interrupt line low until read acknowledges
// - Power-up enters Reset, then Normal Request, or Normal with config pin grounded

// Clock rate in kHz
`define SBCRW_CLK_KHZ         10000
// Reset stretch after the cause clears, in microseconds
`define SBCRW_RST_STRETCH_US  1000
// Normal Request mode timeout, in milliseconds
`define SBCRW_NREQ_TIMEOUT_MS 150
// Fallback watchdog timebase, in milliseconds
`define SBCRW_WD_FALLBACK_MS  150
// Mode select encodings
`define SBCRW_MODE_NORMAL     2'h0
`define SBCRW_MODE_SLEEP      2'h1
`define SBCRW_MODE_STOP       2'h2
// Cycles at the end of a cyclic period with the switch on
`define SBCRW_SENSE_CYC       4
`endif

//--- design/sbcrw_filter.sv
`timescale 1ns/100ps
// Two-stage synchroniser followed by a stability filter per bit
module sbcrw_filter #(
    parameter int         W        = 1,   // Number of bits
    parameter int         FILT_CYC = 1,   // Cycles a new level must stay
    parameter logic [W-1:0] INIT   = '0   // Level shown during reset
) (
    input  wire logic         mclk,      // Clock
    input  wire logic         arst_n,    // Async reset, active low
    input  wire logic [W-1:0] din,       // Asynchronous inputs
    output logic      [W-1:0] dout       // Filtered, synchronous outputs
);
    localparam int CNW = $clog2(FILT_CYC + 1);
    localparam logic [CNW-1:0] LIM = CNW'(FILT_CYC - 1);

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic           s1;          // First stage, read only by s2
            logic           s2;          // Second stage
            logic [CNW-1:0] cnt;         // Stability count

            // Output only moves after the level held for FILT_CYC cycles
            always_ff @(posedge mclk or negedge arst_n) begin
                if (!arst_n) begin
                    s1      <= INIT[i];
                    s2      <= INIT[i];
                    cnt     <= '0;
                    dout[i] <= INIT[i];
                end else begin
                    s1 <= din[i];
                    s2 <= s1;
                    if (s2 == dout[i]) begin
                        cnt <= '0;
                    end else if (cnt == LIM) begin
                        dout[i] <= s2;
                        cnt     <= '0;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
            end
        end
    endgenerate
endmodule // sbcrw_filter

//--- design/sbcrw_pkg.sv
package sbcrw_pkg;
    // Operating modes, Gray coded along power-up, normal and stop path
    typedef enum logic [2:0] {
        SBCRW_RESET  = 3'h0,
        SBCRW_NREQ   = 3'h1,
        SBCRW_NORMAL = 3'h3,
        SBCRW_STOP   = 3'h2,
        SBCRW_SLEEP  = 3'h6
    } sbcrw_mode_t;

    // Timing control fields
    typedef struct packed {
        logic [1:0] prescale;                  // Watchdog divider, shift 0..3
        logic       cyclic_or_watchdog_select; // Enables cyclic or forced wake
        logic [2:0] period_select_bits;        // Low-power period, units minus one
    } sbcrw_timing_control_reg_t;

    // Watchdog status
    typedef struct packed {
        logic watchdog_off_flag;  // Config pin grounded
        logic timebase_fallback;  // Config pin open
    } sbcrw_watchdog_status_reg_t;

    // Wake-up status
    typedef struct packed {
        logic wake_input_level;   // Current wake input level
        logic src_wake_input;     // Direct or cyclic wake seen
        logic src_bus;            // Bus wake seen
        logic src_forced;         // Forced wake seen
    } sbcrw_wakeup_status_reg_t;

    // Pending interrupt sources
    typedef struct packed {
        logic undervolt;
        logic overvolt;
        logic ot_prewarn;
        logic hs_overtemp;
        logic wakeup;
    } sbcrw_irq_t;
endpackage

//--- design/sbcrw_top.sv
`timescale 1ns/100ps
`include "sbcrw_consts.svh"
module sbcrw_top #(
    parameter int unsigned RST_STRETCH_CYC = `SBCRW_RST_STRETCH_US * `SBCRW_CLK_KHZ / 1000,
    parameter int unsigned NREQ_CYC        = `SBCRW_NREQ_TIMEOUT_MS * `SBCRW_CLK_KHZ,
    parameter int unsigned WD_FALLBACK_CYC = `SBCRW_WD_FALLBACK_MS * `SBCRW_CLK_KHZ,
    parameter int unsigned WD_BASE_CYC     = 100000,  // Resistor-set timebase
    parameter int unsigned CYC_UNIT_CYC    = 100000,  // Low-power period unit
    parameter int unsigned BUS_MIN_CYC     = 1000,    // Minimum dominant for bus wake
    parameter int          RST_FILT_CYC    = 30,      // Reset pin glitch filter
    parameter int          CW              = 24       // Timer width
) (
    input  wire logic                mclk,                // Always-on oscillator clock
    input  wire logic                arst_n,              // Async reset, active low
    input  wire logic                vdd_low_pin,         // Regulator below reset threshold
    input  wire logic                reg_overtemp_pin,    // Regulator overtemperature
    input  wire logic                supply_uv_pin,       // Supply below undervolt threshold
    input  wire logic                supply_ov_pin,       // Supply above overvolt threshold
    input  wire logic                reg_prewarn_pin,     // Regulator temperature prewarning
    input  wire logic                hs_overtemp_pin,     // Switch overtemperature shutdown
    input  wire logic                bus_fault_pin,       // Bus fault disabling the driver
    input  wire logic                bus_overcurrent_pin, // Bus overcurrent
    input  wire logic                wdcfg_grounded_pin,  // Config pin sensed grounded
    input  wire logic                wdcfg_open_pin,      // Config pin sensed open
    input  wire logic                wake_input,          // Wake input level
    input  wire logic                bus_rx,              // Bus receiver, low is dominant
    input  wire logic                cs_n,                // Chip select, active low
    input  wire logic                rst_pin_i,           // Reset pin level
    output logic                     rst_pin_o,           // Reset pin drive level
    output logic                     rst_pin_oe,          // Reset pin drive enable
    input  wire logic                mode_wr,             // Mode register write strobe
    input  wire logic [1:0]          mode_select_bits,    // Written mode bits
    input  wire sbcrw_pkg::sbcrw_timing_control_reg_t timing_control_reg, // Timing control
    input  wire logic                wake_input_enable,   // Direct wake enable
    input  wire logic [1:0]          high_side_switch,    // Switch enables
    input  wire logic                amux_wake_sel,       // Wake input on analog mux
    input  wire logic                irq_ack_rd,          // Interrupt acknowledge read
    input  wire logic                bus_status_rd,       // Bus status register read
    output logic                     irq_n,               // Interrupt line, active low
    output logic                     regulator_enable,    // Regulator on
    output logic                     regulator_overtemp_flag, // Sticky overtemp flag
    output logic [1:0]               hs_sense_drive,      // Cyclic sense switch pulses
    output logic                     bus_driver_enable,   // Bus transmitter enabled
    output logic                     bus_overcurrent_flag,// Sticky overcurrent flag
    output sbcrw_pkg::sbcrw_mode_t   op_mode,             // Current mode
    output sbcrw_pkg::sbcrw_watchdog_status_reg_t   watchdog_status_reg, // Watchdog status
    output sbcrw_pkg::sbcrw_wakeup_status_reg_t   wakeup_status_reg,   // Wake-up status
    output sbcrw_pkg::sbcrw_irq_t    irq_src              // Pending interrupts
);
    import sbcrw_pkg::*;

    localparam logic [CW-1:0] STRETCH_LIM = CW'(RST_STRETCH_CYC - 1);
    localparam logic [CW-1:0] NREQ_LIM    = CW'(NREQ_CYC - 1);
    localparam logic [CW-1:0] WD_FB       = CW'(WD_FALLBACK_CYC);
    localparam logic [CW-1:0] WD_BASE     = CW'(WD_BASE_CYC);
    localparam logic [CW-1:0] CYC_UNIT    = CW'(CYC_UNIT_CYC);
    localparam logic [CW-1:0] BUS_MIN     = CW'(BUS_MIN_CYC);
    localparam logic [CW-1:0] SENSE       = CW'(`SBCRW_SENSE_CYC);

    logic [12:0]   sync_v;        // Synchronised plain inputs
    logic          rst_filt;      // Filtered reset pin, low is asserted
    logic          s_vdd_low;     // Synced regulator low
    logic          s_reg_ot;      // Synced regulator overtemp
    logic          s_uv;          // Synced undervolt
    logic          s_ov;          // Synced overvolt
    logic          s_prewarn;     // Synced prewarning
    logic          s_hs_ot;       // Synced switch overtemp
    logic          s_bus_fault;   // Synced bus fault
    logic          s_bus_oc;      // Synced overcurrent
    logic          s_wd_gnd;      // Synced config grounded
    logic          s_wd_open;     // Synced config open
    logic          s_wake;        // Synced wake input
    logic          s_rx;          // Synced bus receiver
    logic          s_cs_n;        // Synced chip select
    sbcrw_mode_t   mode;          // Current mode
    sbcrw_mode_t   next_mode;     // Next mode
    logic [CW-1:0] tmr;           // Reset stretch and Normal Request timer
    logic          int_pending;   // Reset entered by an internal cause
    logic [CW-1:0] wd_cnt;        // Watchdog position in its period
    logic [CW-1:0] cyc_cnt;       // Low-power period position
    logic [CW-1:0] dom_cnt;       // Dominant bus length
    logic          wake_ref;      // Wake input level at last reference
    logic          amux_lat;      // Analog mux selection at low-power entry
    logic [4:0]    prev;          // Previous levels for edge detection
    logic          uv_q;          // Previous undervolt level

    // Plain pins through two flops and a one-cycle filter
    sbcrw_filter #(.W(13), .FILT_CYC(1), .INIT(13'h1803)) u_sync (
        .mclk   (mclk),
        .arst_n (arst_n),
        .din    ({cs_n, bus_rx, wake_input, wdcfg_open_pin, wdcfg_grounded_pin,
                  bus_overcurrent_pin, bus_fault_pin, hs_overtemp_pin, reg_prewarn_pin,
                  supply_ov_pin, supply_uv_pin, reg_overtemp_pin, vdd_low_pin}),
        .dout   (sync_v)
    );

    // Own drive is ORed in so that only an outside low is seen
    sbcrw_filter #(.W(1), .FILT_CYC(RST_FILT_CYC), .INIT(1'b1)) u_rstf (
        .mclk   (mclk),
        .arst_n (arst_n),
        .din    (rst_pin_i | rst_pin_oe),
        .dout   (rst_filt)
    );

    assign {s_cs_n, s_rx, s_wake, s_wd_open, s_wd_gnd, s_bus_oc, s_bus_fault,
            s_hs_ot, s_prewarn, s_ov, s_uv, s_reg_ot, s_vdd_low} = sync_v;

    // Mode and command decode
    wire in_reset   = (mode == SBCRW_RESET);
    wire in_nreq    = (mode == SBCRW_NREQ);
    wire in_normal  = (mode == SBCRW_NORMAL);
    wire in_stop    = (mode == SBCRW_STOP);
    wire in_sleep   = (mode == SBCRW_SLEEP);
    wire low_power  = in_stop | in_sleep;
    wire cmd_normal = mode_wr & (mode_select_bits == `SBCRW_MODE_NORMAL);
    wire cmd_stop   = mode_wr & (mode_select_bits == `SBCRW_MODE_STOP);
    wire cmd_sleep  = mode_wr & (mode_select_bits == `SBCRW_MODE_SLEEP);
    wire ext_low    = ~rst_filt;

    // Watchdog period: fallback or resistor timebase, shifted by prescaler
    wire [CW-1:0] wd_base   = watchdog_status_reg.timebase_fallback ? WD_FB : WD_BASE;
    wire [CW-1:0] wd_period = wd_base << timing_control_reg.prescale;
    wire [CW-1:0] wd_half   = wd_period >> 1;
    wire wd_active  = in_normal & ~watchdog_status_reg.watchdog_off_flag;
    wire wd_early   = wd_active & cmd_normal & (wd_cnt < wd_half);
    wire wd_ok      = wd_active & cmd_normal & ~wd_early;
    wire wd_expire  = wd_active & (wd_cnt == wd_period - 1'b1);
    wire wd_fail    = wd_early | wd_expire;

    // Normal Request timeout, only if no normal command arrives in time
    wire nreq_to    = in_nreq & (tmr == NREQ_LIM) & ~cmd_normal;

    // Low-power wake sources
    wire tsel       = timing_control_reg.cyclic_or_watchdog_select;
    wire cyclic_on  = tsel & wake_input_enable & (|high_side_switch);
    wire forced_on  = tsel & (high_side_switch == 2'h0);
    wire [CW-1:0] cyc_period = CYC_UNIT * (CW'(timing_control_reg.period_select_bits) + 1'b1);
    wire cyc_end    = low_power & (cyc_cnt == cyc_period - 1'b1);
    wire wake_usable = wake_input_enable & ~amux_lat;
    wire wake_diff  = (s_wake != wake_ref);
    wire direct_wk  = low_power & wake_usable & ~cyclic_on & wake_diff;
    wire cyclic_wk  = cyc_end & cyclic_on & wake_usable & wake_diff;
    wire forced_wk  = cyc_end & forced_on;
    wire bus_wk     = low_power & s_rx & ~prev[1] & (dom_cnt > BUS_MIN);
    wire cs_wk      = in_stop & s_cs_n & ~prev[0];
    wire src_wk     = direct_wk | cyclic_wk | forced_wk | bus_wk;
    wire sleep_wk   = in_sleep & src_wk;
    wire stop_wk    = in_stop & (src_wk | cs_wk);

    // Internal reset causes, each stretched on release
    wire int_cause  = s_vdd_low | s_reg_ot | wd_fail | nreq_to | sleep_wk;
    wire stretch_ok = ~int_pending | (tmr == STRETCH_LIM);
    wire after_rst  = watchdog_status_reg.watchdog_off_flag;

    // Next mode; any reset cause overrides everything else
    always_comb begin
        next_mode = mode;
        if (int_cause | ext_low) begin
            next_mode = SBCRW_RESET;
        end else begin
            case (mode)
                SBCRW_RESET: begin
                    if (stretch_ok) begin
                        next_mode = after_rst ? SBCRW_NORMAL : SBCRW_NREQ;
                    end
                end
                SBCRW_NREQ: begin
                    if (cmd_normal) begin
                        next_mode = SBCRW_NORMAL;
                    end
                end
                SBCRW_NORMAL: begin
                    if (cmd_stop) begin
                        next_mode = SBCRW_STOP;
                    end else if (cmd_sleep) begin
                        next_mode = SBCRW_SLEEP;
                    end
                end
                SBCRW_STOP: begin
                    if (stop_wk) begin
                        next_mode = after_rst ? SBCRW_NORMAL : SBCRW_NREQ;
                    end
                end
                default: begin
                    next_mode = mode;
                end
            endcase
        end
    end

    // Mode register and mode timer; timer restarts on each change or cause
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            mode        <= SBCRW_RESET;
            tmr         <= '0;
            int_pending <= 1'b1;
        end else begin
            mode <= next_mode;
            if ((next_mode != mode) | int_cause | ext_low) begin
                tmr <= '0;
            end else begin
                tmr <= tmr + 1'b1;
            end
            if (int_cause) begin
                int_pending <= 1'b1;
            end else if (next_mode != SBCRW_RESET) begin
                int_pending <= 1'b0;
            end
        end
    end

    // Watchdog: config sensed only in Reset; counter runs in Normal only
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            watchdog_status_reg <= '0;
            wd_cnt              <= '0;
        end else begin
            if (in_reset) begin
                watchdog_status_reg.watchdog_off_flag <= s_wd_gnd;
                watchdog_status_reg.timebase_fallback <= s_wd_open & ~s_wd_gnd;
            end
            if (~wd_active | wd_ok) begin
                wd_cnt <= '0;
            end else begin
                wd_cnt <= wd_cnt + 1'b1;
            end
        end
    end

    // Low-power timers, references and sense pulses
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cyc_cnt        <= '0;
            dom_cnt        <= '0;
            wake_ref       <= 1'b0;
            amux_lat       <= 1'b0;
            hs_sense_drive <= 2'h0;
            prev           <= 5'h3;
        end else begin
            prev <= {s_hs_ot, s_prewarn, s_ov, s_rx, s_cs_n};
            cyc_cnt <= (~low_power | cyc_end) ? '0 : cyc_cnt + 1'b1;
            // Dominant length saturates so a stuck bus cannot wrap around
            if (~low_power | s_rx) begin
                dom_cnt <= '0;
            end else if (dom_cnt != '1) begin
                dom_cnt <= dom_cnt + 1'b1;
            end
            if (in_normal & (cmd_stop | cmd_sleep)) begin
                amux_lat <= amux_wake_sel;
                wake_ref <= s_wake;
            end else if (cyc_end) begin
                wake_ref <= s_wake;
            end
            // Switch is pulsed for the last few cycles before each sample
            hs_sense_drive <= (low_power & cyclic_on & (cyc_cnt >= cyc_period - SENSE))
                              ? high_side_switch : 2'h0;
        end
    end

    // Interrupts are only recorded in Normal Request, Normal and Stop with reset released
    wire irq_ok = (in_nreq | in_normal | in_stop) & ~rst_pin_oe;
    sbcrw_irq_t irq_set;
    assign irq_set.undervolt   = irq_ok & s_uv & ~uv_q;
    assign irq_set.overvolt    = irq_ok & s_ov & ~prev[2];
    assign irq_set.ot_prewarn  = irq_ok & s_prewarn & ~prev[3];
    assign irq_set.hs_overtemp = irq_ok & s_hs_ot & ~prev[4];
    assign irq_set.wakeup      = in_stop & src_wk;

    // Sticky flags: a set in the clearing cycle wins
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            uv_q                    <= 1'b0;
            irq_src                 <= '0;
            wakeup_status_reg       <= '0;
            regulator_overtemp_flag <= 1'b0;
            bus_overcurrent_flag    <= 1'b0;
        end else begin
            uv_q    <= s_uv;
            irq_src <= irq_set | (irq_ack_rd ? '0 : irq_src);
            wakeup_status_reg.wake_input_level <= s_wake;
            wakeup_status_reg.src_wake_input <= direct_wk | cyclic_wk |
                (~irq_ack_rd & wakeup_status_reg.src_wake_input);
            wakeup_status_reg.src_bus    <= bus_wk |
                (~irq_ack_rd & wakeup_status_reg.src_bus);
            wakeup_status_reg.src_forced <= forced_wk |
                (~irq_ack_rd & wakeup_status_reg.src_forced);
            regulator_overtemp_flag <= s_reg_ot |
                (~irq_ack_rd & regulator_overtemp_flag);
            bus_overcurrent_flag <= s_bus_oc |
                (~bus_status_rd & bus_overcurrent_flag);
        end
    end

    // Regulator, bus driver and reset pin drive
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            regulator_enable  <= 1'b0;
            bus_driver_enable <= 1'b1;
            rst_pin_oe        <= 1'b1;
        end else begin
            regulator_enable <= (next_mode != SBCRW_SLEEP) & ~s_reg_ot;
            // Overcurrent alone never touches the driver
            if (s_bus_fault) begin
                bus_driver_enable <= 1'b0;
            end else if (bus_status_rd) begin
                bus_driver_enable <= 1'b1;
            end
            // An outside-held reset is not echoed, so the pin stays visible to the filter
            rst_pin_oe <= (next_mode == SBCRW_RESET) & (int_cause | int_pending | ~ext_low);
        end
    end

    assign rst_pin_o = 1'b0;
    assign irq_n     = ~(|irq_src);
    assign op_mode   = mode;
endmodule // sbcrw_top
